/* File: core/cid_decoder.sv */
// Purpose: decodes class, length and operand fields of one fetched instruction
// Assumes: one instruction offered per cycle, inputs synchronous to clk
// Notes:   results appear one clock after the instruction, all from flip-flops
//
// Functional notes
// - add and subtract, with or without carry, word or byte, two or four bytes.
// - two-byte multiply, signed or unsigned, of two named registers.
// - two-byte divide of low product register by a named register, 16 by 16.
// - two-byte long divide of the 32-bit register pair by a named register.
// - two-byte complement and negate of a named register, word or byte.
// - and, or, exclusive-or on word or byte, two or four bytes.
// - bit clear and set use two bytes; bit moves, logic, compare use four.
// - four-byte masked field update of high or low byte from immediate data.
// - compare then step register down by one or two, two or four bytes.
// - compare then step register up by one or two, two or four bytes.
// - two-byte normalise count from one register into another.
// - shifts, rotates and sign-filling right shift use two bytes.
// - byte to word move with sign or zero fill, two or four bytes.
// - conditional jumps and segment jump are four-byte instructions.
// - four-byte bit test branches, optionally clearing or setting the bit.
// - push-and-branch and all calls are four-byte instructions.
// - two-byte trap carrying an immediate trap number.
// - four-byte context switch; plain push and pop use two bytes.
// - two-byte returns from subroutine, segment subroutine and service routine.
// - four-byte sleep instruction decodes legally but does nothing.
// - page and segment prefixes, optional register override, two or four bytes.
// - every coprocessor operation is four bytes long.

`timescale 1ns/10ps

module cid_decoder (
   input  wire logic                   clk,             // system clock
   input  wire logic                   rst,             // synchronous reset
   input  wire logic                   instr_valid,     // fetched word offered
   input  wire logic [31:0]            instr_word,      // fetched bytes
   output logic                        dec_valid,       // decode result valid
   output cid_pkg::cid_class_t         dec_class,       // instruction class
   output cid_pkg::cid_op_t            dec_op,          // opcode family
   output logic [1:0]                  dec_variant,     // raw variant bits
   output logic                        dec_len_four,    // 1: four bytes, 0: two
   output logic                        dec_byte_width,  // byte-wide operands
   output logic [3:0]                  dec_reg_dst,     // first register
   output logic [3:0]                  dec_reg_src,     // second register
   output logic [15:0]                 dec_ext_data,    // second word, long forms
   output logic                        dec_signed,      // signed operation
   output logic                        dec_step_two,    // step by two
   output logic                        dec_step_down,   // step downwards
   output logic                        dec_bit_modify,  // bit written
   output logic                        dec_bit_value,   // value written to bit
   output logic                        dec_shift_right, // shift direction
   output logic                        dec_shift_arith, // sign fill on shift
   output logic                        dec_rotate,      // rotate, not shift
   output logic                        dec_long_div,    // 32-bit dividend
   output logic                        dec_pop_reg,     // pop a register
   output logic                        dec_field_high,  // high byte field
   output logic [6:0]                  dec_trap_num,    // trap number
   output logic                        dec_no_action,   // legal, no effect
   output logic                        dec_prefix_reg,  // register override
   output logic [3:0]                  dec_cop_func,    // coprocessor function
   output logic                        dec_illegal,     // unknown family
   output logic                        sys_restart,     // software restart
   output logic                        sys_idle,        // idle entry
   output logic                        sys_wdt_service, // watchdog service
   output logic                        sys_wdt_disable, // watchdog disable
   output logic                        sys_wdt_enable,  // watchdog enable
   output logic                        sys_init_lock    // end of init lock
);

   localparam int DQ_W = 63;

   // class of each opcode family
   function automatic cid_pkg::cid_class_t class_of(input cid_pkg::cid_op_t f);
      case (f)
         cid_pkg::F_ADD, cid_pkg::F_ADDC,
         cid_pkg::F_SUB, cid_pkg::F_SUBC,
         cid_pkg::F_CPL, cid_pkg::F_NEG,
         cid_pkg::F_NORM: class_of = cid_pkg::C_ARITH;
         cid_pkg::F_MUL, cid_pkg::F_DIV,
         cid_pkg::F_DIVL: class_of = cid_pkg::C_MULDIV;
         cid_pkg::F_AND, cid_pkg::F_OR,
         cid_pkg::F_XOR: class_of = cid_pkg::C_LOGIC;
         cid_pkg::F_BITSC, cid_pkg::F_BMOV,
         cid_pkg::F_BLOG, cid_pkg::F_BCMP,
         cid_pkg::F_BFLD: class_of = cid_pkg::C_BIT;
         cid_pkg::F_CMP, cid_pkg::F_CMPD,
         cid_pkg::F_CMPI: class_of = cid_pkg::C_CMP;
         cid_pkg::F_SHIFT, cid_pkg::F_ROT,
         cid_pkg::F_SFILL: class_of = cid_pkg::C_SHIFT;
         cid_pkg::F_MOV, cid_pkg::F_MOVX,
         cid_pkg::F_STACK, cid_pkg::F_CTXSW: class_of = cid_pkg::C_MOVE;
         cid_pkg::F_JMP, cid_pkg::F_JMPSEG,
         cid_pkg::F_JBH, cid_pkg::F_JBL: class_of = cid_pkg::C_BRANCH;
         cid_pkg::F_CALL, cid_pkg::F_CALLSG,
         cid_pkg::F_PUSH_AND_BRANCH_OP, cid_pkg::F_TRAP: class_of = cid_pkg::C_CALL;
         cid_pkg::F_RET, cid_pkg::F_RETSG,
         cid_pkg::F_ISRX: class_of = cid_pkg::C_RETURN;
         cid_pkg::F_BREAK, cid_pkg::F_RESTA,
         cid_pkg::F_IDLE, cid_pkg::F_SLEEP,
         cid_pkg::F_WDSRV, cid_pkg::F_WDCTL,
         cid_pkg::F_LOCK: class_of = cid_pkg::C_SYSTEM;
         cid_pkg::F_ATOM, cid_pkg::F_EXREG,
         cid_pkg::F_EXPAG, cid_pkg::F_EXSEG: class_of = cid_pkg::C_PREFIX;
         cid_pkg::F_COP: class_of = cid_pkg::C_COPROC;
         cid_pkg::F_NOP: class_of = cid_pkg::C_NOP;
         default: class_of = cid_pkg::C_ILLEGAL;
      endcase
   endfunction

   // byte length: dual forms follow the long bit, fixed forms are four or two
   function automatic logic four_of(input cid_pkg::cid_op_t f, input logic lng);
      case (f)
         cid_pkg::F_ADD, cid_pkg::F_ADDC,
         cid_pkg::F_SUB, cid_pkg::F_SUBC,
         cid_pkg::F_AND, cid_pkg::F_OR,
         cid_pkg::F_XOR, cid_pkg::F_CMP,
         cid_pkg::F_CMPD, cid_pkg::F_CMPI,
         cid_pkg::F_MOV, cid_pkg::F_MOVX,
         cid_pkg::F_EXPAG, cid_pkg::F_EXSEG: four_of = lng;
         cid_pkg::F_BMOV, cid_pkg::F_BLOG,
         cid_pkg::F_BCMP, cid_pkg::F_BFLD,
         cid_pkg::F_JMP, cid_pkg::F_JMPSEG,
         cid_pkg::F_JBH, cid_pkg::F_JBL,
         cid_pkg::F_CALL, cid_pkg::F_CALLSG,
         cid_pkg::F_PUSH_AND_BRANCH_OP, cid_pkg::F_CTXSW,
         cid_pkg::F_RESTA, cid_pkg::F_IDLE,
         cid_pkg::F_SLEEP, cid_pkg::F_WDSRV,
         cid_pkg::F_WDCTL, cid_pkg::F_LOCK,
         cid_pkg::F_COP: four_of = 1'b1;
         default: four_of = 1'b0;
      endcase
   endfunction

   // opcode family and variant of the offered word
   cid_pkg::cid_op_t fam;
   logic [1:0]       v;
   assign fam = cid_pkg::cid_op_t'(instr_word[cid_pkg::FAM_MSB:cid_pkg::FAM_LSB]);
   assign v   = instr_word[cid_pkg::VAR_ALT:cid_pkg::VAR_LONG];

   // family groups
   logic is_muldiv;
   logic is_cmpstep;
   logic is_bitbr;
   logic width_ok;
   assign is_muldiv  = fam inside {cid_pkg::F_MUL, cid_pkg::F_DIV, cid_pkg::F_DIVL};
   assign is_cmpstep = fam inside {cid_pkg::F_CMPD, cid_pkg::F_CMPI};
   assign is_bitbr   = fam inside {cid_pkg::F_JBH, cid_pkg::F_JBL};
   assign width_ok   = fam inside {cid_pkg::F_ADD, cid_pkg::F_ADDC, cid_pkg::F_SUB,
                                   cid_pkg::F_SUBC, cid_pkg::F_CPL, cid_pkg::F_NEG,
                                   cid_pkg::F_AND, cid_pkg::F_OR, cid_pkg::F_XOR,
                                   cid_pkg::F_CMP, cid_pkg::F_MOV};

   // next decode results
   cid_pkg::cid_class_t next_class;
   logic                next_illegal;
   logic                next_len_four;
   logic                next_byte_width;
   logic                next_signed;
   logic                next_step_two;
   logic                next_step_down;
   logic                next_bit_modify;
   logic                next_bit_value;
   logic                next_shift_right;
   logic                next_shift_arith;
   logic                next_rotate;
   logic                next_long_div;
   logic                next_pop_reg;
   logic                next_field_high;
   logic [6:0]          next_trap_num;
   logic                next_no_action;
   logic                next_prefix_reg;
   logic [3:0]          next_cop_func;
   logic [15:0]         next_ext_data;
   logic                take;
   logic [5:0]          next_sys;

   assign next_class      = class_of(fam);
   assign next_illegal    = (next_class == cid_pkg::C_ILLEGAL);
   assign next_len_four   = four_of(fam, v[cid_pkg::VAR_LONG]);
   assign next_byte_width = width_ok & v[cid_pkg::VAR_ALT];
   // factors signed unless flagged unsigned; extension signed unless zero fill
   assign next_signed     = (is_muldiv & ~v[cid_pkg::VAR_LONG])
                          | ((fam == cid_pkg::F_MOVX) & ~v[cid_pkg::VAR_ALT])
                          | (fam == cid_pkg::F_SFILL);
   assign next_step_two   = is_cmpstep & v[cid_pkg::VAR_ALT];
   assign next_step_down  = (fam == cid_pkg::F_CMPD);
   // bit clear/set writes variant value; bit branches modify on request
   assign next_bit_modify = (fam == cid_pkg::F_BITSC)
                          | (is_bitbr & v[cid_pkg::VAR_ALT]);
   assign next_bit_value  = (fam == cid_pkg::F_BITSC) ? v[cid_pkg::VAR_LONG]
                          : (fam == cid_pkg::F_JBL);
   assign next_shift_right = ((fam == cid_pkg::F_SHIFT) & v[cid_pkg::VAR_LONG])
                           | ((fam == cid_pkg::F_ROT) & v[cid_pkg::VAR_LONG])
                           | (fam == cid_pkg::F_SFILL);
   assign next_shift_arith = (fam == cid_pkg::F_SFILL);
   assign next_rotate      = (fam == cid_pkg::F_ROT);
   assign next_long_div    = (fam == cid_pkg::F_DIVL);
   assign next_pop_reg     = ((fam == cid_pkg::F_RET) & v[cid_pkg::VAR_LONG])
                           | ((fam == cid_pkg::F_STACK) & v[cid_pkg::VAR_LONG]);
   assign next_field_high  = (fam == cid_pkg::F_BFLD) & v[cid_pkg::VAR_LONG];
   assign next_trap_num    = (fam == cid_pkg::F_TRAP)
                           ? instr_word[cid_pkg::TRP_MSB:cid_pkg::TRP_LSB]
                           : 7'h00;
   assign next_no_action   = (fam == cid_pkg::F_SLEEP);
   assign next_prefix_reg  = (fam == cid_pkg::F_EXREG)
                           | ((fam inside {cid_pkg::F_EXPAG, cid_pkg::F_EXSEG})
                              & v[cid_pkg::VAR_ALT]);
   assign next_cop_func    = (fam == cid_pkg::F_COP)
                           ? instr_word[cid_pkg::COP_MSB:cid_pkg::COP_LSB]
                           : 4'h0;
   // immediate, mask/data or target word only exists in long forms
   assign next_ext_data    = next_len_four
                           ? instr_word[cid_pkg::EXT_MSB:cid_pkg::EXT_LSB]
                           : 16'h0000;

   // system control strobes, only for a legal offered instruction
   assign take     = instr_valid & ~next_illegal;
   assign next_sys = {6{take}} & {(fam == cid_pkg::F_RESTA),
                                  (fam == cid_pkg::F_IDLE),
                                  (fam == cid_pkg::F_WDSRV),
                                  (fam == cid_pkg::F_WDCTL) & ~v[cid_pkg::VAR_LONG],
                                  (fam == cid_pkg::F_WDCTL) & v[cid_pkg::VAR_LONG],
                                  (fam == cid_pkg::F_LOCK)};

   // result bundle
   logic [DQ_W-1:0] next_dq;
   logic [DQ_W-1:0] dq;
   logic [5:0]      sys_q;
   logic            valid_q;
   assign next_dq = {next_class, fam, v, next_len_four, next_byte_width,
                     instr_word[cid_pkg::DST_MSB:cid_pkg::DST_LSB],
                     instr_word[cid_pkg::SRC_MSB:cid_pkg::SRC_LSB],
                     next_ext_data, next_signed, next_step_two, next_step_down,
                     next_bit_modify, next_bit_value, next_shift_right,
                     next_shift_arith, next_rotate, next_long_div, next_pop_reg,
                     next_field_high, next_trap_num, next_no_action,
                     next_prefix_reg, next_cop_func, next_illegal};

   // one pipeline stage between fetch and execution
   always_ff @(posedge clk) begin
      if (rst) begin
         dq      <= '0;
         sys_q   <= '0;
         valid_q <= 1'b0;
      end else begin
         dq      <= next_dq;
         sys_q   <= next_sys;
         valid_q <= instr_valid;
      end
   end

   // outputs are plain slices of the result flops
   assign dec_class = cid_pkg::cid_class_t'(dq[DQ_W-1:DQ_W-4]);
   assign dec_op    = cid_pkg::cid_op_t'(dq[DQ_W-5:DQ_W-10]);
   assign {dec_variant, dec_len_four, dec_byte_width, dec_reg_dst, dec_reg_src,
           dec_ext_data, dec_signed, dec_step_two, dec_step_down, dec_bit_modify,
           dec_bit_value, dec_shift_right, dec_shift_arith, dec_rotate,
           dec_long_div, dec_pop_reg, dec_field_high, dec_trap_num,
           dec_no_action, dec_prefix_reg, dec_cop_func, dec_illegal} = dq[DQ_W-11:0];
   assign {sys_restart, sys_idle, sys_wdt_service, sys_wdt_disable,
           sys_wdt_enable, sys_init_lock} = sys_q;
   assign dec_valid = valid_q;

   // add, subtract with carry and xor length follows the long bit
   property p_arith_len;
      @(posedge clk) disable iff (rst)
      (fam inside {cid_pkg::F_ADD, cid_pkg::F_SUBC, cid_pkg::F_XOR})
      |=> (dec_len_four == $past(instr_word[0]));
   endproperty
   a_arith_len: assert property (p_arith_len) else $error("dual length wrong");

   // multiply is two bytes with signedness from the variant
   property p_mul;
      @(posedge clk) disable iff (rst)
      (fam == cid_pkg::F_MUL) |=> (!dec_len_four && dec_class == cid_pkg::C_MULDIV
                                   && dec_signed == !$past(instr_word[0]));
   endproperty
   a_mul: assert property (p_mul) else $error("multiply decode wrong");

   // short and long divide differ only in dividend width
   property p_div;
      @(posedge clk) disable iff (rst)
      (fam inside {cid_pkg::F_DIV, cid_pkg::F_DIVL})
      |=> (!dec_len_four && dec_long_div == ($past(fam) == cid_pkg::F_DIVL));
   endproperty
   a_div: assert property (p_div) else $error("divide decode wrong");

   // bit clear/set short, two-bit operations long
   property p_bit_len;
      @(posedge clk) disable iff (rst)
      (dec_class == cid_pkg::C_BIT)
      |-> (dec_len_four == ($past(fam) != cid_pkg::F_BITSC));
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("bit length wrong");

   // compare-and-step amount and direction
   property p_cmp_step;
      @(posedge clk) disable iff (rst)
      is_cmpstep |=> (dec_step_two == $past(instr_word[1])
                      && dec_step_down == ($past(fam) == cid_pkg::F_CMPD));
   endproperty
   a_cmp_step: assert property (p_cmp_step) else $error("step decode wrong");

   // branches and calls other than trap are always four bytes
   property p_flow_len;
      @(posedge clk) disable iff (rst)
      (dec_class inside {cid_pkg::C_BRANCH, cid_pkg::C_CALL}
       && dec_op != cid_pkg::F_TRAP) |-> dec_len_four;
   endproperty
   a_flow_len: assert property (p_flow_len) else $error("branch length wrong");

   // sleep decodes legal and quiet
   property p_sleep;
      @(posedge clk) disable iff (rst)
      (instr_valid && fam == cid_pkg::F_SLEEP)
      |=> (dec_no_action && !dec_illegal && dec_len_four && sys_q == 6'h00);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not quiet");

   // restart strobe only in the cycle after an offered restart
   property p_restart;
      @(posedge clk) disable iff (rst)
      sys_restart |-> $past(instr_valid && fam == cid_pkg::F_RESTA);
   endproperty
   a_restart: assert property (p_restart) else $error("stray restart");

   // coprocessor work is four bytes
   property p_cop;
      @(posedge clk) disable iff (rst)
      (dec_class == cid_pkg::C_COPROC) |-> (dec_len_four && !dec_illegal);
   endproperty
   a_cop: assert property (p_cop) else $error("coprocessor length wrong");

   // shifts are two bytes, sign fill only for the arithmetic form
   property p_shift;
      @(posedge clk) disable iff (rst)
      (dec_class == cid_pkg::C_SHIFT)
      |-> (!dec_len_four && dec_shift_arith == (dec_op == cid_pkg::F_SFILL));
   endproperty
   a_shift: assert property (p_shift) else $error("shift decode wrong");

endmodule

/* File: core/cid_pkg.sv */
// Purpose: shared constants and types for the instruction class decoder
// Assumes: first two instruction bytes sit in bits 15:0 of the fetched word
// Notes:   opcode family and variant layout is a local encoding

package cid_pkg;

   // word layout of a fetched instruction
   localparam int FAM_LSB  = 2;   // opcode family field
   localparam int FAM_MSB  = 7;
   localparam int VAR_LONG = 0;   // variant bit: long form / alternate
   localparam int VAR_ALT  = 1;   // variant bit: byte width / second flavour
   localparam int DST_LSB  = 8;   // first register field
   localparam int DST_MSB  = 11;
   localparam int SRC_LSB  = 12;  // second register field
   localparam int SRC_MSB  = 15;
   localparam int EXT_LSB  = 16;  // second instruction word
   localparam int EXT_MSB  = 31;
   localparam int TRP_LSB  = 8;   // trap number field
   localparam int TRP_MSB  = 14;
   localparam int COP_LSB  = 16;  // coprocessor function field
   localparam int COP_MSB  = 19;

   localparam int WORD_W   = 32;
   localparam int REG_W    = 4;
   localparam int EXT_W    = 16;
   localparam int TRP_W    = 7;
   localparam int COP_W    = 4;
   localparam int SYS_W    = 6;

   // opcode families
   typedef enum logic [5:0] {
      F_NOP    = 6'h00, F_ADD   = 6'h01, F_ADDC  = 6'h02, F_SUB    = 6'h03,
      F_SUBC   = 6'h04, F_MUL   = 6'h05, F_DIV   = 6'h06, F_DIVL   = 6'h07,
      F_CPL    = 6'h08, F_NEG   = 6'h09, F_AND   = 6'h0A, F_OR     = 6'h0B,
      F_XOR    = 6'h0C, F_BITSC = 6'h0D, F_BMOV  = 6'h0E, F_BLOG   = 6'h0F,
      F_BCMP   = 6'h10, F_BFLD  = 6'h11, F_CMP   = 6'h12, F_CMPD   = 6'h13,
      F_CMPI   = 6'h14, F_NORM  = 6'h15, F_SHIFT = 6'h16, F_ROT    = 6'h17,
      F_SFILL  = 6'h18, F_MOV   = 6'h19, F_MOVX  = 6'h1A, F_JMP    = 6'h1B,
      F_JMPSEG = 6'h1C, F_JBH   = 6'h1D, F_JBL   = 6'h1E, F_CALL   = 6'h1F,
      F_CALLSG = 6'h20, F_PUSH_AND_BRANCH_OP = 6'h21, F_TRAP  = 6'h22, F_STACK  = 6'h23,
      F_CTXSW  = 6'h24, F_RET   = 6'h25, F_RETSG = 6'h26, F_ISRX   = 6'h27,
      F_BREAK  = 6'h28, F_RESTA = 6'h29, F_IDLE  = 6'h2A, F_SLEEP  = 6'h2B,
      F_WDSRV  = 6'h2C, F_WDCTL = 6'h2D, F_LOCK  = 6'h2E, F_ATOM   = 6'h2F,
      F_EXREG  = 6'h30, F_EXPAG = 6'h31, F_EXSEG = 6'h32, F_COP    = 6'h33
   } cid_op_t;

   // instruction classes handed to execution
   typedef enum logic [3:0] {
      C_NONE    = 4'h0, C_ARITH  = 4'h1, C_MULDIV = 4'h2, C_LOGIC  = 4'h3,
      C_BIT     = 4'h4, C_CMP    = 4'h5, C_SHIFT  = 4'h6, C_MOVE   = 4'h7,
      C_BRANCH  = 4'h8, C_CALL   = 4'h9, C_RETURN = 4'hA, C_SYSTEM = 4'hB,
      C_PREFIX  = 4'hC, C_COPROC = 4'hD, C_NOP    = 4'hE, C_ILLEGAL = 4'hF
   } cid_class_t;

endpackage

/* File: testbench/cid_decoder_bench.sv */
// Purpose: self-checking bench for the instruction class decoder
// Assumes: inputs change at the falling edge, results read at the next falling edge
// Notes:   the bench stands in for the fetch stage on the word inputs
`timescale 1ns/10ps
module cid_decoder_bench;
   logic                clk = 1'b0, rst = 1'b1, iv = 1'b0;
   logic         [31:0] iw  = 32'h0000_0000;
   logic                dv, lf, il, sg, ld, na, s2, sd, bw, bm, bv, sr, sa, ro, pr, fh, px;
   logic          [5:0] sy;
   logic          [3:0] cf, rd, rs;
   logic          [1:0] va;
   cid_pkg::cid_op_t    op;
   logic          [6:0] tn;
   logic         [15:0] ed, fa;
   cid_pkg::cid_class_t cl;
   int                  n_fail = 0, checks_done = 0, cyc = 0;
   // clock and cycle ceiling
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         end_of_test();
      end
   end
   cid_decoder dut (.clk(clk), .rst(rst), .instr_valid(iv), .instr_word(iw), .dec_valid(dv),
      .dec_class(cl), .dec_op(op), .dec_variant(va), .dec_len_four(lf), .dec_byte_width(bw),
      .dec_reg_dst(rd), .dec_reg_src(rs), .dec_ext_data(ed), .dec_signed(sg), .dec_step_two(s2),
      .dec_step_down(sd), .dec_bit_modify(bm), .dec_bit_value(bv), .dec_shift_right(sr),
      .dec_shift_arith(sa), .dec_rotate(ro), .dec_long_div(ld), .dec_pop_reg(pr),
      .dec_field_high(fh), .dec_trap_num(tn), .dec_no_action(na), .dec_prefix_reg(px),
      .dec_cop_func(cf), .dec_illegal(il), .sys_restart(sy[0]), .sys_idle(sy[1]),
      .sys_wdt_service(sy[2]), .sys_wdt_disable(sy[3]), .sys_wdt_enable(sy[4]),
      .sys_init_lock(sy[5]));
   cid_fetch_model fm (.clk(clk), .rst(rst), .dec_valid(dv), .dec_len_four(lf), .fetch_addr(fa));
   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // compare tasks for flags and for wider values
   task automatic chk_bit(logic got, logic exp, string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask
   task automatic chk_val(logic [15:0] got, logic [15:0] exp, string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // offer one word at the falling edge and return when its result has settled
   task automatic offer(logic [5:0] f, logic [1:0] v, logic [15:0] hi, logic [7:0] lo);
      iw = {hi, lo, f, v};
      iv = 1'b1;
      @(negedge clk);
   endtask
   // expected length: fixed by family, bit0 picks the long form where both exist
   function automatic logic exp_len(logic [5:0] f, logic v0);
      case (f)
         6'h01, 6'h02, 6'h03, 6'h04, 6'h0A, 6'h0B, 6'h0C, 6'h12, 6'h13, 6'h14,
         6'h19, 6'h1A, 6'h31, 6'h32: exp_len = v0;
         6'h0E, 6'h0F, 6'h10, 6'h11, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h20,
         6'h21, 6'h24, 6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h33: exp_len = 1'b1;
         default: exp_len = 1'b0;
      endcase
   endfunction
   // expected system strobes in port order restart, idle, service, disable, enable, lock
   function automatic logic [5:0] exp_sys(logic [5:0] f, logic v0);
      case (f)
         6'h29: exp_sys = 6'h01;
         6'h2A: exp_sys = 6'h02;
         6'h2C: exp_sys = 6'h04;
         6'h2D: exp_sys = v0 ? 6'h10 : 6'h08;
         6'h2E: exp_sys = 6'h20;
         default: exp_sys = 6'h00;
      endcase
   endfunction
   // every family and variant back to back, then the undefined families
   task automatic t_sweep();
      logic [15:0] pc;
      logic        l;
      pc = fa;
      for (int f = 0; f < 52; f++) begin
         for (int v = 0; v < 4; v++) begin
            l  = exp_len(f[5:0], v[0]);
            pc = pc + (l ? 16'h0004 : 16'h0002);
            offer(f[5:0], v[1:0], 16'hA5C3, 8'h00);
            chk_bit(lf, l, "length");
            chk_val(ed, l ? 16'hA5C3 : 16'h0000, "second word");
            chk_val({10'h000, sy}, {10'h000, exp_sys(f[5:0], v[0])}, "strobe");
            chk_bit(il, 1'b0, "legal flag");
         end
      end
      iv = 1'b0;
      @(negedge clk);
      chk_bit(dv, 1'b0, "valid dropped");
      chk_val(fa, pc, "boundary");
      for (int f = 52; f < 64; f++) begin
         offer(f[5:0], 2'b01, 16'h0000, 8'h00);
         chk_bit(il, 1'b1, "undefined");
         chk_val({12'h000, cl}, {12'h000, cid_pkg::C_ILLEGAL}, "class");
         chk_val({10'h000, sy}, 16'h0000, "no strobe");
      end
   endtask
   // operand fields of multiply, divide, compare-step, trap, coprocessor, sleep
   task automatic t_fields();
      offer(6'h05, 2'b00, 16'h0000, 8'h00);
      chk_bit(sg, 1'b1, "signed multiply");
      offer(6'h06, 2'b01, 16'h0000, 8'h00);
      chk_bit(ld, 1'b0, "short divide");
      offer(6'h07, 2'b00, 16'h0000, 8'h00);
      chk_bit(ld, 1'b1, "long divide");
      offer(6'h13, 2'b10, 16'h0000, 8'h00);
      chk_val({14'h0000, s2, sd}, 16'h0003, "step down two");
      offer(6'h14, 2'b00, 16'h0000, 8'h00);
      chk_val({14'h0000, s2, sd}, 16'h0000, "step up one");
      offer(6'h22, 2'b00, 16'h0000, 8'hD5);
      chk_val({9'h000, tn}, 16'h0055, "trap number");
      offer(6'h33, 2'b00, 16'h000B, 8'h00);
      chk_val({12'h000, cf}, 16'h000B, "coprocessor function");
      chk_val({12'h000, cl}, {12'h000, cid_pkg::C_COPROC}, "coprocessor class");
      offer(6'h2B, 2'b00, 16'h0000, 8'h00);
      chk_bit(na, 1'b1, "sleep no action");
   endtask
   // width, register fields, bit, shift, extension, pop, field and prefix flags
   task automatic t_modes();
      offer(6'h0C, 2'b10, 16'h0000, 8'h7E);
      chk_val({7'h00, bw, rs, rd}, 16'h017E, "byte xor registers");
      chk_val({8'h00, op, va}, 16'h0032, "family and variant");
      offer(6'h0D, 2'b01, 16'h0000, 8'h00);
      chk_val({14'h0000, bm, bv}, 16'h0003, "bit set");
      offer(6'h1E, 2'b10, 16'h0000, 8'h00);
      chk_val({14'h0000, bm, bv}, 16'h0003, "branch low and set");
      offer(6'h1D, 2'b00, 16'h0000, 8'h00);
      chk_val({14'h0000, bm, bv}, 16'h0000, "branch high");
      offer(6'h18, 2'b00, 16'h0000, 8'h00);
      chk_val({12'h000, sg, sr, sa, ro}, 16'h000E, "sign fill right");
      offer(6'h17, 2'b00, 16'h0000, 8'h00);
      chk_val({12'h000, sg, sr, sa, ro}, 16'h0001, "rotate left");
      offer(6'h1A, 2'b10, 16'h0000, 8'h00);
      chk_bit(sg, 1'b0, "zero extend");
      offer(6'h25, 2'b01, 16'h0000, 8'h00);
      chk_bit(pr, 1'b1, "return and pop");
      offer(6'h11, 2'b01, 16'h0000, 8'h00);
      chk_bit(fh, 1'b1, "high byte field");
      offer(6'h32, 2'b10, 16'h0000, 8'h00);
      chk_bit(px, 1'b1, "segment and register");
   endtask
   // restart strobe, then a restart offered under reset must give nothing
   task automatic t_reset();
      offer(6'h29, 2'b00, 16'h0000, 8'h00);
      chk_bit(sy[0], 1'b1, "restart strobe");
      rst = 1'b1;
      offer(6'h29, 2'b00, 16'h0000, 8'h00);
      chk_val({5'h00, sy, dv, cl}, 16'h0000, "reset clears");
      rst = 1'b0;
      iv  = 1'b0;
      @(negedge clk);
      chk_bit(dv, 1'b0, "idle after reset");
      offer(6'h29, 2'b00, 16'h0000, 8'h00);
      chk_bit(sy[0], 1'b1, "restart after reset");
      iv = 1'b0;
   endtask
   // main sequence
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_sweep();
      t_fields();
      t_modes();
      t_reset();
      end_of_test();
   end
endmodule

/* File: testbench/cid_fetch_model.sv */
// Purpose: fetch side model that follows instruction boundaries
// Assumes: the decoded length arrives one clock after each offered word
// Notes:   only the boundary counter of the fetch stage is modelled
`timescale 1ns/10ps
module cid_fetch_model (
   input  wire logic        clk,          // system clock
   input  wire logic        rst,          // synchronous reset
   input  wire logic        dec_valid,    // decode result valid
   input  wire logic        dec_len_four, // decoded length, 1 = four bytes
   output logic      [15:0] fetch_addr    // next instruction boundary
);
   // step the boundary by the decoded length of each valid result
   always_ff @(posedge clk) begin
      if (rst) fetch_addr <= 16'h0000;
      else if (dec_valid) fetch_addr <= fetch_addr + (dec_len_four ? 16'h0004 : 16'h0002);
   end
endmodule
